// [core/csr_store_map.vh]
/*
 register store decoder constants: opcode fields, source selects, timing.
 assumes: included by the decoder, source mux and store unit files only.
*/
`ifndef CSR_STORE_MAP_VH
`define CSR_STORE_MAP_VH

// opcode fields
`define CSR_MAJ_DIRECT      4'h0
`define CSR_MAJ_PUSH        4'h4
// low byte, direct forms
`define CSR_D_STATUS        8'h02
`define CSR_D_GBASE         8'h12
`define CSR_D_VBASE         8'h22
`define CSR_D_CIRC          8'h52
`define CSR_D_LSTOP         8'h72
`define CSR_D_LBEGIN        8'h62
`define CSR_D_MAC_HIGH          8'h0A
`define CSR_D_MAC_LOW          8'h1A
`define CSR_D_RET           8'h2A
`define CSR_D_DFLAGS        8'h6A
`define CSR_D_ACC0          8'h7A
`define CSR_D_X0            8'h8A
`define CSR_D_X1            8'h9A
`define CSR_D_Y0            8'hAA
`define CSR_D_Y1            8'hBA
// low byte, push forms
`define CSR_P_STATUS        8'h03
`define CSR_P_GBASE         8'h13
`define CSR_P_VBASE         8'h23
`define CSR_P_CIRC          8'h53
`define CSR_P_LSTOP         8'h73
`define CSR_P_LBEGIN        8'h63
`define CSR_P_MAC_HIGH          8'h02
`define CSR_P_MAC_LOW          8'h12
`define CSR_P_RET           8'h22
`define CSR_P_DFLAGS        8'h62
`define CSR_P_ACC0          8'h72
`define CSR_P_X0            8'h82
`define CSR_P_X1            8'h92
`define CSR_P_Y0            8'hA2
`define CSR_P_Y1            8'hB2
// source selects
`define CSR_S_STATUS        4'h0
`define CSR_S_GBASE         4'h1
`define CSR_S_VBASE         4'h2
`define CSR_S_CIRC          4'h3
`define CSR_S_LSTOP         4'h4
`define CSR_S_LBEGIN        4'h5
`define CSR_S_MAC_HIGH          4'h6
`define CSR_S_MAC_LOW          4'h7
`define CSR_S_RET           4'h8
`define CSR_S_DFLAGS        4'h9
`define CSR_S_ACC0          4'hA
`define CSR_S_X0            4'hB
`define CSR_S_X1            4'hC
`define CSR_S_Y0            4'hD
`define CSR_S_Y1            4'hE
// variants
`define CSR_VAR_LEGACY      2'h0
`define CSR_VAR_BASE        2'h1
`define CSR_VAR_DSP         2'h2
// arithmetic and timing
`define CSR_PUSH_DEC        32'h00000004
`define CSR_PC_STEP         32'h00000002
`define CSR_MAC_HIGH_SIGN_BIT   9
`define CSR_MAC_HIGH_LOW_MASK   32'h000003FF
`define CSR_MAC_HIGH_HIGH_FILL  32'hFFFFFC00
`define CSR_CTRL_PUSH_CYC   2'h2
`define CSR_SYS_PUSH_CYC    2'h1

`endif

// [core/csr_decode.v]
/*
 combinational opcode decoder for the register store instructions.
 assumes: opcode is stable while valid; variant fixed at build.
*/
`timescale 1ns/1ps
`include "csr_store_map.vh"

module csr_decode #(
    parameter [1:0] VARIANT = `CSR_VAR_DSP
) (
    input  wire [15:0] opcode_in,
    output reg         hit_out,
    output reg         push_out,
    output reg         ctrl_out,
    output reg         illegal_out,
    output reg  [3:0]  src_out
);
    reg dsp_only;
    always @* begin
        hit_out     = 1'b0;
        push_out    = 1'b0;
        ctrl_out    = 1'b0;
        dsp_only    = 1'b0;
        src_out     = `CSR_S_STATUS;
        if (opcode_in[15:12] == `CSR_MAJ_DIRECT) begin
            hit_out = 1'b1;
            case (opcode_in[7:0])
                `CSR_D_STATUS: begin src_out = `CSR_S_STATUS; ctrl_out = 1'b1; end
                `CSR_D_GBASE:  begin src_out = `CSR_S_GBASE;  ctrl_out = 1'b1; end
                `CSR_D_VBASE:  begin src_out = `CSR_S_VBASE;  ctrl_out = 1'b1; end
                `CSR_D_CIRC:   begin src_out = `CSR_S_CIRC;   ctrl_out = 1'b1; dsp_only = 1'b1; end
                `CSR_D_LSTOP:  begin src_out = `CSR_S_LSTOP;  ctrl_out = 1'b1; dsp_only = 1'b1; end
                `CSR_D_LBEGIN: begin src_out = `CSR_S_LBEGIN; ctrl_out = 1'b1; dsp_only = 1'b1; end
                `CSR_D_MAC_HIGH:   src_out = `CSR_S_MAC_HIGH;
                `CSR_D_MAC_LOW:   src_out = `CSR_S_MAC_LOW;
                `CSR_D_RET:    src_out = `CSR_S_RET;
                `CSR_D_DFLAGS: begin src_out = `CSR_S_DFLAGS; dsp_only = 1'b1; end
                `CSR_D_ACC0:   begin src_out = `CSR_S_ACC0;   dsp_only = 1'b1; end
                `CSR_D_X0:     begin src_out = `CSR_S_X0;     dsp_only = 1'b1; end
                `CSR_D_X1:     begin src_out = `CSR_S_X1;     dsp_only = 1'b1; end
                `CSR_D_Y0:     begin src_out = `CSR_S_Y0;     dsp_only = 1'b1; end
                `CSR_D_Y1:     begin src_out = `CSR_S_Y1;     dsp_only = 1'b1; end
                default:       hit_out = 1'b0;
            endcase
        end else if (opcode_in[15:12] == `CSR_MAJ_PUSH) begin
            hit_out  = 1'b1;
            push_out = 1'b1;
            case (opcode_in[7:0])
                `CSR_P_STATUS: begin src_out = `CSR_S_STATUS; ctrl_out = 1'b1; end
                `CSR_P_GBASE:  begin src_out = `CSR_S_GBASE;  ctrl_out = 1'b1; end
                `CSR_P_VBASE:  begin src_out = `CSR_S_VBASE;  ctrl_out = 1'b1; end
                `CSR_P_CIRC:   begin src_out = `CSR_S_CIRC;   ctrl_out = 1'b1; dsp_only = 1'b1; end
                `CSR_P_LSTOP:  begin src_out = `CSR_S_LSTOP;  ctrl_out = 1'b1; dsp_only = 1'b1; end
                `CSR_P_LBEGIN: begin src_out = `CSR_S_LBEGIN; ctrl_out = 1'b1; dsp_only = 1'b1; end
                `CSR_P_MAC_HIGH:   src_out = `CSR_S_MAC_HIGH;
                `CSR_P_MAC_LOW:   src_out = `CSR_S_MAC_LOW;
                `CSR_P_RET:    src_out = `CSR_S_RET;
                `CSR_P_DFLAGS: begin src_out = `CSR_S_DFLAGS; dsp_only = 1'b1; end
                // accumulator push moved to its own code
                `CSR_P_ACC0:   begin src_out = `CSR_S_ACC0;   dsp_only = 1'b1; end
                `CSR_P_X0:     begin src_out = `CSR_S_X0;     dsp_only = 1'b1; end
                `CSR_P_X1:     begin src_out = `CSR_S_X1;     dsp_only = 1'b1; end
                `CSR_P_Y0:     begin src_out = `CSR_S_Y0;     dsp_only = 1'b1; end
                `CSR_P_Y1:     begin src_out = `CSR_S_Y1;     dsp_only = 1'b1; end
                default:       hit_out = 1'b0;
            endcase
        end
        illegal_out = hit_out && dsp_only && (VARIANT != `CSR_VAR_DSP);
        if (illegal_out) begin
            hit_out = 1'b0;
        end
    end
endmodule // csr_decode

// [core/csr_source_mux.v]
/*
 source register select with variant-dependent mac_high shaping.
 assumes: source values come from the core register set, same clock.
*/
`timescale 1ns/1ps
`include "csr_store_map.vh"

module csr_source_mux #(
    parameter [1:0] VARIANT = `CSR_VAR_DSP
) (
    input  wire [3:0]  sel_in,
    input  wire [31:0] status_in,
    input  wire [31:0] gbase_in,
    input  wire [31:0] vbase_in,
    input  wire [31:0] circ_in,
    input  wire [31:0] lstop_in,
    input  wire [31:0] lbegin_in,
    input  wire [31:0] mac_high_in,
    input  wire [31:0] mac_low_in,
    input  wire [31:0] ret_in,
    input  wire [31:0] dflags_in,
    input  wire [31:0] acc0_in,
    input  wire [31:0] x0_in,
    input  wire [31:0] x1_in,
    input  wire [31:0] y0_in,
    input  wire [31:0] y1_in,
    output reg  [31:0] value_out
);
    reg [31:0] mac_high_v;
    always @* begin
        mac_high_v = mac_high_in;
        if (VARIANT == `CSR_VAR_LEGACY) begin
            if (mac_high_in[`CSR_MAC_HIGH_SIGN_BIT])
                mac_high_v = mac_high_in | `CSR_MAC_HIGH_HIGH_FILL;
            else
                mac_high_v = mac_high_in & `CSR_MAC_HIGH_LOW_MASK;
        end
        // later variants keep all 32 bits
        case (sel_in)
            `CSR_S_STATUS: value_out = status_in;
            `CSR_S_GBASE:  value_out = gbase_in;
            `CSR_S_VBASE:  value_out = vbase_in;
            `CSR_S_CIRC:   value_out = circ_in;
            `CSR_S_LSTOP:  value_out = lstop_in;
            `CSR_S_LBEGIN: value_out = lbegin_in;
            `CSR_S_MAC_HIGH:   value_out = mac_high_v;
            `CSR_S_MAC_LOW:   value_out = mac_low_in;
            `CSR_S_RET:    value_out = ret_in;
            `CSR_S_DFLAGS: value_out = dflags_in;
            `CSR_S_ACC0:   value_out = acc0_in;
            `CSR_S_X0:     value_out = x0_in;
            `CSR_S_X1:     value_out = x1_in;
            `CSR_S_Y0:     value_out = y0_in;
            `CSR_S_Y1:     value_out = y1_in;
            default:       value_out = 32'h00000000;
        endcase
    end
endmodule // csr_source_mux

// [core/csr_store_unit.v]
/*
 execute unit for control and system register stores (direct copy and push).
 assumes: pipeline issues one instruction per valid pulse and waits for done;
 register file reads dest_gpr value combinationally; memory accepts write on ack.
*/
// How it works
// - status_word, global_base and vector_base copy into dest_gpr in one cycle on all variants.
// - circ_bounds, loop_stop_addr and loop_begin_addr copy into dest_gpr in one cycle on the dsp variant only.
// - control pushes of status_word, global_base and vector_base decrement dest_gpr by 4 then write it, in two cycles.
// - the same two-cycle push exists for circ_bounds, loop_stop_addr and loop_begin_addr on the dsp variant.
// - after any of these stores interrupts stay blocked until the next instruction has executed.
// - address errors stay live, so a misaligned push address raises one despite the interrupt hold.
// - mac_high, mac_low and return_addr copy into dest_gpr in one cycle on all variants.
// - dsp_flags, dsp_accum0 and the x/y operands copy into dest_gpr in one cycle on the dsp variant.
// - system pushes of mac_high, mac_low and return_addr decrement dest_gpr by 4 and write, listed as one cycle; the unit runs them like control pushes.
// - dsp_flags and the x/y operands have pre-decrement pushes on the dsp variant.
// - the dsp_accum0 push, printed with the dsp_flags code, takes its own code following the direct pattern.
// - on the legacy variant the stored mac_high has bit 9 copied into bits 31 to 10.
// - on base and dsp variants mac_high is stored as all 32 bits.
`timescale 1ns/1ps
`include "csr_store_map.vh"

module csr_store_unit #(
    parameter [1:0] VARIANT = `CSR_VAR_DSP
) (
    // clock and reset
    input  wire        CLOCK_IN,
    input  wire        RESET_IN,
    // instruction issue
    input  wire        INSN_VALID_IN,
    input  wire [15:0] INSN_OPCODE_IN,
    input  wire [31:0] PC_IN,
    input  wire        NEXT_INSN_DONE_IN,
    // source registers
    input  wire [31:0] STATUS_WORD_IN,
    input  wire [31:0] GLOBAL_BASE_IN,
    input  wire [31:0] VECTOR_BASE_IN,
    input  wire [31:0] CIRC_BOUNDS_IN,
    input  wire [31:0] LOOP_STOP_ADDR_IN,
    input  wire [31:0] LOOP_BEGIN_ADDR_IN,
    input  wire [31:0] MAC_HIGH_IN,
    input  wire [31:0] MAC_LOW_IN,
    input  wire [31:0] RETURN_ADDR_IN,
    input  wire [31:0] DSP_FLAGS_IN,
    input  wire [31:0] DSP_ACCUM0_IN,
    input  wire [31:0] X_OPERAND0_IN,
    input  wire [31:0] X_OPERAND1_IN,
    input  wire [31:0] Y_OPERAND0_IN,
    input  wire [31:0] Y_OPERAND1_IN,
    // register file
    input  wire [31:0] DEST_GPR_VALUE_IN,
    output reg         GPR_WE_OUT,
    output reg  [3:0]  GPR_IDX_OUT,
    output reg  [31:0] GPR_DATA_OUT,
    // memory write
    input  wire        MEM_ACK_IN,
    output reg         MEM_WR_OUT,
    output reg  [31:0] MEM_ADDR_OUT,
    output reg  [31:0] MEM_DATA_OUT,
    // control to core
    output reg         BUSY_OUT,
    output reg         DONE_OUT,
    output reg  [31:0] PC_NEXT_OUT,
    output reg         IRQ_BLOCK_OUT,
    output reg         ADDR_ERR_OUT,
    output reg         ILLEGAL_OUT
);
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_WRITE = 2'h1;
    localparam [1:0] ST_WAIT  = 2'h2;

    wire        dec_hit;
    wire        dec_push;
    wire        dec_illegal;
    wire [3:0]  dec_src;
    wire [31:0] src_value;
    wire [31:0] dec_addr;
    wire        take;

    reg [1:0]   state_ff;
    reg [1:0]   nxt_state;
    reg [31:0]  push_data_ff;
    reg [31:0]  push_addr_ff;
    reg [31:0]  pc_next_ff;

    csr_decode #(
        .VARIANT     (VARIANT)
    ) u_decode (
        .opcode_in   (INSN_OPCODE_IN),
        .hit_out     (dec_hit),
        .push_out    (dec_push),
        .ctrl_out    (),
        .illegal_out (dec_illegal),
        .src_out     (dec_src)
    );

    csr_source_mux #(
        .VARIANT     (VARIANT)
    ) u_mux (
        .sel_in      (dec_src),
        .status_in   (STATUS_WORD_IN),
        .gbase_in    (GLOBAL_BASE_IN),
        .vbase_in    (VECTOR_BASE_IN),
        .circ_in     (CIRC_BOUNDS_IN),
        .lstop_in    (LOOP_STOP_ADDR_IN),
        .lbegin_in   (LOOP_BEGIN_ADDR_IN),
        .mac_high_in     (MAC_HIGH_IN),
        .mac_low_in     (MAC_LOW_IN),
        .ret_in      (RETURN_ADDR_IN),
        .dflags_in   (DSP_FLAGS_IN),
        .acc0_in     (DSP_ACCUM0_IN),
        .x0_in       (X_OPERAND0_IN),
        .x1_in       (X_OPERAND1_IN),
        .y0_in       (Y_OPERAND0_IN),
        .y1_in       (Y_OPERAND1_IN),
        .value_out   (src_value)
    );

    assign take     = INSN_VALID_IN && (state_ff == ST_IDLE);
    assign dec_addr = DEST_GPR_VALUE_IN - `CSR_PUSH_DEC;

    // push sequencing
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take && dec_hit && dec_push)
                    nxt_state = ST_WRITE;
            end
            ST_WRITE: begin
                // a faulting push skips the memory wait
                if (push_addr_ff[1:0] != 2'h0)
                    nxt_state = ST_IDLE;
                else
                    nxt_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (MEM_ACK_IN)
                    nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_ff      <= ST_IDLE;
            push_data_ff  <= 32'h00000000;
            push_addr_ff  <= 32'h00000000;
            pc_next_ff    <= 32'h00000000;
            GPR_WE_OUT    <= 1'b0;
            GPR_IDX_OUT   <= 4'h0;
            GPR_DATA_OUT  <= 32'h00000000;
            MEM_WR_OUT    <= 1'b0;
            MEM_ADDR_OUT  <= 32'h00000000;
            MEM_DATA_OUT  <= 32'h00000000;
            BUSY_OUT      <= 1'b0;
            DONE_OUT      <= 1'b0;
            PC_NEXT_OUT   <= 32'h00000000;
            IRQ_BLOCK_OUT <= 1'b0;
            ADDR_ERR_OUT  <= 1'b0;
            ILLEGAL_OUT   <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            GPR_WE_OUT   <= 1'b0;
            DONE_OUT     <= 1'b0;
            ADDR_ERR_OUT <= 1'b0;
            ILLEGAL_OUT  <= 1'b0;
            // hold ends once the following instruction retires
            if (NEXT_INSN_DONE_IN)
                IRQ_BLOCK_OUT <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (take && dec_illegal) begin
                        ILLEGAL_OUT <= 1'b1;
                    end else if (take && dec_hit) begin
                        IRQ_BLOCK_OUT <= 1'b1;
                        pc_next_ff    <= PC_IN + `CSR_PC_STEP;
                        GPR_IDX_OUT   <= INSN_OPCODE_IN[11:8];
                        GPR_WE_OUT    <= 1'b1;
                        if (dec_push) begin
                            GPR_DATA_OUT <= dec_addr;
                            push_addr_ff <= dec_addr;
                            push_data_ff <= src_value;
                            BUSY_OUT     <= 1'b1;
                        end else begin
                            GPR_DATA_OUT <= src_value;
                            DONE_OUT     <= 1'b1;
                            PC_NEXT_OUT  <= PC_IN + `CSR_PC_STEP;
                        end
                    end
                end
                ST_WRITE: begin
                    if (push_addr_ff[1:0] != 2'h0) begin
                        ADDR_ERR_OUT <= 1'b1;
                        BUSY_OUT     <= 1'b0;
                        DONE_OUT     <= 1'b1;
                        PC_NEXT_OUT  <= pc_next_ff;
                    end else begin
                        MEM_WR_OUT   <= 1'b1;
                        MEM_ADDR_OUT <= push_addr_ff;
                        MEM_DATA_OUT <= push_data_ff;
                    end
                end
                ST_WAIT: begin
                    if (MEM_ACK_IN) begin
                        MEM_WR_OUT  <= 1'b0;
                        BUSY_OUT    <= 1'b0;
                        DONE_OUT    <= 1'b1;
                        PC_NEXT_OUT <= pc_next_ff;
                    end
                end
                default: begin
                    BUSY_OUT <= 1'b0;
                end
            endcase
        end
    end
endmodule // csr_store_unit

// [testbench/csr_store_asserts.sv]
/*
 checker for the register store unit: copy, push and interrupt hold timing at the ports.
 assumes: bound to every csr_store_unit instance, one clock, async active-high reset.
*/
`timescale 1ns/1ps

module csr_store_asserts #(
    parameter [1:0] VARIANT = 2'h2
) (
    input wire        CLOCK_IN,
    input wire        RESET_IN,
    input wire        INSN_VALID_IN,
    input wire [15:0] INSN_OPCODE_IN,
    input wire [31:0] PC_IN,
    input wire        NEXT_INSN_DONE_IN,
    input wire [31:0] MAC_HIGH_IN,
    input wire [31:0] DEST_GPR_VALUE_IN,
    input wire        MEM_ACK_IN,
    input wire        GPR_WE_OUT,
    input wire [3:0]  GPR_IDX_OUT,
    input wire [31:0] GPR_DATA_OUT,
    input wire        MEM_WR_OUT,
    input wire [31:0] MEM_ADDR_OUT,
    input wire [31:0] MEM_DATA_OUT,
    input wire        BUSY_OUT,
    input wire        DONE_OUT,
    input wire [31:0] PC_NEXT_OUT,
    input wire        IRQ_BLOCK_OUT,
    input wire        ADDR_ERR_OUT,
    input wire        ILLEGAL_OUT
);
    wire [7:0]  lo       = INSN_OPCODE_IN[7:0];
    wire [3:0]  hi       = lo[7:4];
    wire        dsp      = VARIANT == 2'h2;
    wire        take     = INSN_VALID_IN && !BUSY_OUT;
    wire        grp_a    = hi <= 4'h2 || dsp && hi >= 4'h5 && hi <= 4'h7;
    wire        grp_b    = hi <= 4'h2 || dsp && hi >= 4'h6 && hi <= 4'hB;
    wire        dir_op   = INSN_OPCODE_IN[15:12] == 4'h0 && (lo[3:0] == 4'h2 && grp_a || lo[3:0] == 4'hA && grp_b);
    wire        push_op  = INSN_OPCODE_IN[15:12] == 4'h4 && (lo[3:0] == 4'h3 && grp_a || lo[3:0] == 4'h2 && grp_b);
    wire        dsp_dir  = !dsp && INSN_OPCODE_IN[15:12] == 4'h0 && lo[3:0] == 4'hA && hi >= 4'h6 && hi <= 4'hB;
    wire        mac_high_dir = INSN_OPCODE_IN[15:12] == 4'h0 && lo == 8'h0A;
    wire [31:0] mac_high_exp = VARIANT == 2'h0 ? {{22{MAC_HIGH_IN[9]}}, MAC_HIGH_IN[9:0]} : MAC_HIGH_IN;

    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);

    sequence s_push_take;
        take && push_op && DEST_GPR_VALUE_IN[1:0] == 2'h0;
    endsequence
    sequence s_push_bad;
        take && push_op && DEST_GPR_VALUE_IN[1:0] != 2'h0;
    endsequence

    direct_copy_a: assert property (take && dir_op |=> GPR_WE_OUT && DONE_OUT &&
        GPR_IDX_OUT == $past(INSN_OPCODE_IN[11:8]) && PC_NEXT_OUT == $past(PC_IN) + 32'h2)
        else $error("direct copy result or timing wrong");
    push_dec_a: assert property (s_push_take |=> GPR_WE_OUT && BUSY_OUT &&
        GPR_DATA_OUT == $past(DEST_GPR_VALUE_IN) - 32'h4)
        else $error("push pointer not decremented by four");
    push_write_a: assert property (s_push_take |=> ##1 MEM_WR_OUT &&
        MEM_ADDR_OUT == $past(DEST_GPR_VALUE_IN, 2) - 32'h4)
        else $error("push write missing or at wrong address");
    misalign_err_a: assert property (s_push_bad |=> ##1 ADDR_ERR_OUT && DONE_OUT && !MEM_WR_OUT)
        else $error("misaligned push without address error");
    irq_raise_a: assert property (take && (dir_op || push_op) |=> IRQ_BLOCK_OUT)
        else $error("interrupt hold not raised after store");
    irq_keep_a: assert property (IRQ_BLOCK_OUT && !NEXT_INSN_DONE_IN |=> IRQ_BLOCK_OUT)
        else $error("interrupt hold dropped before next instruction");
    mem_hold_a: assert property (MEM_WR_OUT && !MEM_ACK_IN |=>
        MEM_WR_OUT && $stable(MEM_ADDR_OUT) && $stable(MEM_DATA_OUT))
        else $error("memory write changed before acknowledge");
    push_end_a: assert property (MEM_WR_OUT && MEM_ACK_IN |=> !MEM_WR_OUT && DONE_OUT && !BUSY_OUT)
        else $error("push did not finish after acknowledge");
    mac_high_shape_a: assert property (take && mac_high_dir |=> GPR_DATA_OUT == $past(mac_high_exp))
        else $error("stored mac_high shaping wrong");
    illegal_dsp_a: assert property (take && dsp_dir |=> ILLEGAL_OUT && !GPR_WE_OUT && !DONE_OUT)
        else $error("dsp code accepted on non-dsp build");
endmodule // csr_store_asserts

bind csr_store_unit csr_store_asserts #(.VARIANT(VARIANT)) u_chk (.*);

// [testbench/csr_core_model.sv]
/*
 core side model: register file read by index and longword memory that acknowledges writes.
 assumes: same clock as the store unit; ack delay set by the bench.
*/
`timescale 1ns/1ps

module csr_core_model (
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_in,
    // register file
    input  wire [3:0]  rd_idx_in,
    output wire [31:0] rd_data_out,
    input  wire        we_in,
    input  wire [3:0]  wr_idx_in,
    input  wire [31:0] wr_data_in,
    // memory
    input  wire        mem_wr_in,
    input  wire [31:0] mem_addr_in,
    input  wire [31:0] mem_data_in,
    input  wire [1:0]  ack_dly_in,
    output reg         ack_out,
    output reg  [31:0] last_addr_out,
    output reg  [31:0] last_data_out
);
    logic [31:0] rf_ff [16];
    logic [1:0]  wait_ff;

    assign rd_data_out = rf_ff[rd_idx_in];

    always @(posedge clk_in) begin
        if (we_in)
            rf_ff[wr_idx_in] <= wr_data_in;
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_out <= 1'b0;
            wait_ff <= 2'h0;
            last_addr_out <= 32'h0;
            last_data_out <= 32'h0;
        end else if (mem_wr_in && !ack_out && wait_ff == ack_dly_in) begin
            ack_out <= 1'b1;
            wait_ff <= 2'h0;
            last_addr_out <= mem_addr_in;
            last_data_out <= mem_data_in;
        end else begin
            ack_out <= 1'b0;
            wait_ff <= (mem_wr_in && !ack_out) ? wait_ff + 2'h1 : 2'h0;
        end
    end
endmodule // csr_core_model

// [testbench/csr_store_unit_tb.sv]
/*
 testbench for the register store unit: dsp build checked in full, legacy build beside it.
 assumes: core model answers register reads and memory writes.
*/
`timescale 1ns/1ps

module csr_store_unit_tb;
    logic        CLOCK_IN, RESET_IN, INSN_VALID_IN, NEXT_INSN_DONE_IN;
    logic [15:0] INSN_OPCODE_IN;
    logic [31:0] PC_IN;
    logic [14:0][31:0] src;
    logic [1:0]  ack_dly;
    wire  [31:0] STATUS_WORD_IN = src[0], GLOBAL_BASE_IN = src[1], VECTOR_BASE_IN = src[2];
    wire  [31:0] CIRC_BOUNDS_IN = src[3], LOOP_STOP_ADDR_IN = src[4], LOOP_BEGIN_ADDR_IN = src[5];
    wire  [31:0] MAC_HIGH_IN = src[6], MAC_LOW_IN = src[7], RETURN_ADDR_IN = src[8], DSP_FLAGS_IN = src[9];
    wire  [31:0] DSP_ACCUM0_IN = src[10], X_OPERAND0_IN = src[11], X_OPERAND1_IN = src[12];
    wire  [31:0] Y_OPERAND0_IN = src[13], Y_OPERAND1_IN = src[14];
    wire         MEM_ACK_IN, GPR_WE_OUT, MEM_WR_OUT, BUSY_OUT, DONE_OUT, IRQ_BLOCK_OUT, ADDR_ERR_OUT, ILLEGAL_OUT;
    wire  [3:0]  GPR_IDX_OUT;
    wire  [31:0] DEST_GPR_VALUE_IN, GPR_DATA_OUT, MEM_ADDR_OUT, MEM_DATA_OUT, PC_NEXT_OUT;
    wire  [31:0] leg_gdata, last_addr, last_data;
    wire         leg_ill;
    logic [7:0]  dir_code [15] = '{8'h02, 8'h12, 8'h22, 8'h52, 8'h72, 8'h62, 8'h0A, 8'h1A, 8'h2A,
                                   8'h6A, 8'h7A, 8'h8A, 8'h9A, 8'hAA, 8'hBA};
    logic [7:0]  push_code [15] = '{8'h03, 8'h13, 8'h23, 8'h53, 8'h73, 8'h63, 8'h02, 8'h12, 8'h22,
                                    8'h62, 8'h72, 8'h82, 8'h92, 8'hA2, 8'hB2};
    int          error_cnt, checks_done;

    csr_store_unit #(.VARIANT(2'h2)) dut (.*);
    csr_store_unit #(.VARIANT(2'h0)) dut_leg (.GPR_WE_OUT(), .GPR_IDX_OUT(), .GPR_DATA_OUT(leg_gdata),
        .MEM_WR_OUT(), .MEM_ADDR_OUT(), .MEM_DATA_OUT(), .BUSY_OUT(), .DONE_OUT(), .PC_NEXT_OUT(),
        .IRQ_BLOCK_OUT(), .ADDR_ERR_OUT(), .ILLEGAL_OUT(leg_ill), .*);
    csr_core_model model (.clk_in(CLOCK_IN), .rst_in(RESET_IN), .rd_idx_in(INSN_OPCODE_IN[11:8]),
        .rd_data_out(DEST_GPR_VALUE_IN), .we_in(GPR_WE_OUT), .wr_idx_in(GPR_IDX_OUT), .wr_data_in(GPR_DATA_OUT),
        .mem_wr_in(MEM_WR_OUT), .mem_addr_in(MEM_ADDR_OUT), .mem_data_in(MEM_DATA_OUT), .ack_dly_in(ack_dly),
        .ack_out(MEM_ACK_IN), .last_addr_out(last_addr), .last_data_out(last_data));

    function automatic logic [31:0] shape(input logic [31:0] v);
        return {{22{v[9]}}, v[9:0]};
    endfunction

    function automatic bit dsp_only(input int k);
        return (k >= 3 && k <= 5) || k >= 9;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic issue(input logic [15:0] op, input bit b9);
        for (int i = 0; i < 15; i++)
            src[i] = $urandom;
        src[6][9] = b9;
        PC_IN = $urandom & 32'hFFFFFFFE;
        INSN_OPCODE_IN = op;
        INSN_VALID_IN = 1'b1;
        @(negedge CLOCK_IN);
    endtask

    task automatic wait_done(output bit wr_seen);
        int n;
        wr_seen = 1'b0;
        n = 0;
        while (DONE_OUT !== 1'b1) begin
            wr_seen |= MEM_WR_OUT === 1'b1;
            n++;
            if (n > 20) begin
                error_cnt++;
                complete_run();
            end
            @(negedge CLOCK_IN);
        end
    endtask

    task automatic retire;
        NEXT_INSN_DONE_IN = 1'b1;
        @(negedge CLOCK_IN);
        NEXT_INSN_DONE_IN = 1'b0;
        check(IRQ_BLOCK_OUT, 1'b0);
    endtask

    initial begin
        CLOCK_IN = 1'b0;
        forever #10 CLOCK_IN = ~CLOCK_IN;
    end

    initial begin
        bit          wr;
        bit          bad;
        logic [31:0] base;
        logic [3:0]  rn;
        int          j;
        RESET_IN = 1'b1;
        INSN_VALID_IN = 1'b0;
        INSN_OPCODE_IN = 16'h0;
        PC_IN = 32'h0;
        NEXT_INSN_DONE_IN = 1'b0;
        ack_dly = 2'h0;
        src = '0;
        error_cnt = 0;
        checks_done = 0;
        j = $urandom(32'hDA5D);
        repeat (2) @(negedge CLOCK_IN);
        RESET_IN = 1'b0;
        // direct copies back to back, every code, both mac_high bit 9 values
        for (int k = 0; k < 30; k++) begin
            j = k % 15;
            rn = $urandom;
            issue({4'h0, rn, dir_code[j]}, k >= 15);
            check(GPR_WE_OUT & DONE_OUT, 1'b1);
            check(GPR_IDX_OUT, rn);
            check(GPR_DATA_OUT, src[j]);
            check(PC_NEXT_OUT, PC_IN + 32'h2);
            check(IRQ_BLOCK_OUT, 1'b1);
            check(leg_ill, dsp_only(j));
            check(ILLEGAL_OUT, 1'b0);
            if (!dsp_only(j))
                check(leg_gdata, j == 6 ? shape(src[6]) : src[j]);
        end
        INSN_VALID_IN = 1'b0;
        retire();
        // pushes with stalled acknowledge, every fifth one misaligned
        for (int k = 0; k < 30; k++) begin
            j = k % 15;
            rn = $urandom;
            bad = k % 5 == 4;
            ack_dly = $urandom;
            base = ($urandom & 32'hFFFFFFFC) | (bad ? 32'h2 : 32'h0);
            model.rf_ff[rn] = base;
            issue({4'h4, rn, push_code[j]}, k[0]);
            INSN_VALID_IN = 1'b0;
            check(GPR_DATA_OUT, base - 32'h4);
            check(BUSY_OUT | ADDR_ERR_OUT, 1'b1);
            check(leg_ill, dsp_only(j));
            wait_done(wr);
            check(ADDR_ERR_OUT, bad);
            check(wr, !bad);
            if (!bad)
                check(last_addr, base - 32'h4);
            if (!bad)
                check(last_data, src[j]);
            check(model.rf_ff[rn], base - 32'h4);
            check(PC_NEXT_OUT, PC_IN + 32'h2);
            check(IRQ_BLOCK_OUT, 1'b1);
            retire();
        end
        complete_run();
    end
endmodule // csr_store_unit_tb
